// *** core/ssw_pkg.sv ***
// Package of constants and carrier types for the supply supervisor watchdog
// Summary of operation
// - Hold reset output low while the supply-low indication is active.
// - Keep reset low 200 ms after supply-low clears, then release.
// - Active-high reset output is always the inverse of active-low reset.
// - Manual reset input low asserts processor reset like a low supply.
// - Manual reset is debounced: reset stays low 200 ms after it rises.
// - No kick transition for 1.60 s drives the watchdog flag low.
// - Any rising or falling kick transition restarts the watchdog count.
// - Watchdog count is held clear while reset is asserted.
// - Supply-low forces the watchdog flag low regardless of the timer.
// - Floating kick input disables watchdog timing; flag then follows supply only.
// - Power-fail flag is low while the sense comparator reports below reference.
// - Timed-out flag stays low until a kick transition, reset or a floating kick input clears it.
// - Flag returns high when supply-low clears unless timeout still pending.
package ssw_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned STRETCH_MS = 200;
  localparam int unsigned WDOG_MS = 1600;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned STRETCH_TICKS = STRETCH_MS * 1000 / TICK_US;
  localparam int unsigned WDOG_TICKS = WDOG_MS * 1000 / TICK_US;
  localparam int unsigned CNT_W = 16;
  localparam logic RST_N_RESET = 1'b0;
  localparam logic FLAG_N_RESET = 1'b1;

  // Kick input as sensed by the three-level front end
  typedef struct packed {
    logic level;
    logic floating;
  } ssw_kick_t;

  typedef struct packed {
    logic reset_n;
    logic reset;
    logic watchdog_flag_n;
    logic power_fail_flag_n;
  } ssw_out_t;
endpackage

// *** core/ssw_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/10ps
module ssw_sync #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// *** core/ssw_top.sv ***
// Supply supervisor: reset stretch, manual reset, watchdog and power-fail flag
`timescale 1ns/10ps
module ssw_top
  import ssw_pkg::*;
#(
  parameter int unsigned STRETCH_TICKS_P = ssw_pkg::STRETCH_TICKS,
  parameter int unsigned WDOG_TICKS_P = ssw_pkg::WDOG_TICKS,
  parameter int unsigned TICK_CYC_P = ssw_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Comparator indications
  input wire logic supply_low_in,
  input wire logic supply_sense_in,
  // Processor side inputs
  input wire logic manual_reset_n,
  input wire ssw_pkg::ssw_kick_t watchdog_kick_in,
  // Supervisor outputs
  output ssw_pkg::ssw_out_t sup_out
);
  import ssw_pkg::*;

  logic [3:0] raw_in;
  logic [3:0] sync_in;
  logic supply_low_s, sense_ok_s, mr_n_s, kick_s, kick_float_s;
  logic kick_float_reg;
  logic kick_prev_reg;
  logic kick_edge;
  logic [CNT_W-1:0] tick_cnt_reg;
  logic tick;
  logic [CNT_W-1:0] stretch_cnt_reg;
  logic reset_req;
  logic reset_n_reg;
  logic reset_reg;
  logic [CNT_W-1:0] wdog_cnt_reg;
  logic timeout_reg;
  logic wdog_flag_n_reg;
  logic pfo_n_reg;

  // Active-low levels go in inverted so the synchroniser's zero reset reads as idle
  assign raw_in = {supply_low_in, !supply_sense_in, !manual_reset_n, watchdog_kick_in.level};

  ssw_sync #(
    .W(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(raw_in),
    .q(sync_in)
  );

  // Float detect is synchronised separately, reset to floating so no spurious kick
  logic float_meta_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      float_meta_reg <= 1'b1;
      kick_float_reg <= 1'b1;
    end else begin
      float_meta_reg <= watchdog_kick_in.floating;
      kick_float_reg <= float_meta_reg;
    end
  end

  assign supply_low_s = sync_in[3];
  assign sense_ok_s = !sync_in[2];
  assign mr_n_s = !sync_in[1];
  assign kick_s = sync_in[0];
  assign kick_float_s = kick_float_reg;

  // Time base tick
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  assign tick = (tick_cnt_reg == CNT_W'(TICK_CYC_P - 1));

  // Reset request; manual reset shares the supply path so it is debounced too
  assign reset_req = supply_low_s || !mr_n_s;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stretch_cnt_reg <= '0;
      reset_n_reg <= RST_N_RESET;
      reset_reg <= !RST_N_RESET;
    end else if (reset_req) begin
      stretch_cnt_reg <= '0;
      reset_n_reg <= 1'b0;
      reset_reg <= 1'b1;
    end else if (!reset_n_reg && tick) begin
      if (stretch_cnt_reg == CNT_W'(STRETCH_TICKS_P - 1)) begin
        reset_n_reg <= 1'b1;
        reset_reg <= 1'b0;
      end else begin
        stretch_cnt_reg <= stretch_cnt_reg + 1'b1;
      end
    end
  end

  // Kick edge detect on the synchronised level only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= kick_s;
    end
  end
  assign kick_edge = (kick_s != kick_prev_reg) && !kick_float_s;

  // Watchdog count; timeout sticks until a kick, reset or a floating kick clears it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wdog_cnt_reg <= '0;
      timeout_reg <= 1'b0;
    end else if (!reset_n_reg || kick_float_s) begin
      wdog_cnt_reg <= '0;
      timeout_reg <= 1'b0;
    end else if (kick_edge) begin
      wdog_cnt_reg <= '0;
      timeout_reg <= 1'b0;
    end else if (tick && !timeout_reg) begin
      if (wdog_cnt_reg == CNT_W'(WDOG_TICKS_P - 1)) begin
        timeout_reg <= 1'b1;
      end else begin
        wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
      end
    end
  end

  // Flag outputs; timeout never feeds the reset path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wdog_flag_n_reg <= FLAG_N_RESET;
      pfo_n_reg <= FLAG_N_RESET;
    end else begin
      wdog_flag_n_reg <= !(supply_low_s || timeout_reg);
      pfo_n_reg <= sense_ok_s;
    end
  end

  always_comb begin
    sup_out.reset_n = reset_n_reg;
    sup_out.reset = reset_reg;
    sup_out.watchdog_flag_n = wdog_flag_n_reg;
    sup_out.power_fail_flag_n = pfo_n_reg;
  end

  // Helper: cycles reset has been released
  logic [CNT_W-1:0] rel_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !reset_n_reg) begin
      rel_cnt_reg <= '0;
    end else if (rel_cnt_reg != '1) begin
      rel_cnt_reg <= rel_cnt_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  low_holds_a: assert property (supply_low_s |=> !reset_n_reg)
    else $error("reset released during supply low");
  stretch_min_a: assert property ($fell(reset_req) |-> !reset_n_reg [*8])
    else $error("reset released too early after request");
  stretch_ticks_a: assert property ($rose(reset_n_reg) |->
      $past(stretch_cnt_reg) == CNT_W'(STRETCH_TICKS_P - 1) && $past(tick))
    else $error("reset released before stretch count done");
  invert_out_a: assert property (sup_out.reset == !sup_out.reset_n)
    else $error("active high reset not inverse");
  manual_holds_a: assert property (!mr_n_s |=> !reset_n_reg)
    else $error("manual reset did not assert reset");
  wdog_clear_a: assert property (!reset_n_reg |=> wdog_cnt_reg == '0 && !timeout_reg)
    else $error("watchdog count not cleared in reset");
  kick_restart_a: assert property (kick_edge && reset_n_reg |=> wdog_cnt_reg == '0)
    else $error("kick did not restart count");
  timeout_flag_a: assert property (timeout_reg |=> !wdog_flag_n_reg)
    else $error("timeout did not lower flag");
  supply_flag_a: assert property (supply_low_s |=> !wdog_flag_n_reg)
    else $error("supply low did not force flag");
  float_off_a: assert property (kick_float_s |=> !timeout_reg)
    else $error("watchdog timing while floating");
  flag_sticky_a: assert property (timeout_reg && !kick_edge && reset_n_reg && !kick_float_s
      |=> timeout_reg)
    else $error("timeout cleared without kick or reset");
  flag_return_a: assert property (!supply_low_s && !timeout_reg |=> wdog_flag_n_reg)
    else $error("flag not released");
  wdog_late_a: assert property ($rose(timeout_reg) |->
      rel_cnt_reg >= CNT_W'((WDOG_TICKS_P - 1) * TICK_CYC_P))
    else $error("watchdog timed out too soon after reset release");
  pfo_follow_a: assert property (##1 pfo_n_reg == $past(sense_ok_s))
    else $error("power fail flag wrong");
  no_reset_on_timeout_a: assert property (timeout_reg && !reset_req |=> reset_n_reg
      || $past(!reset_n_reg))
    else $error("timeout asserted reset");

  cov_release_c: cover property ($rose(reset_n_reg));
  cov_timeout_c: cover property ($rose(timeout_reg));
  cov_kick_c: cover property (kick_edge && reset_n_reg && wdog_cnt_reg != '0);
  cov_pfail_c: cover property ($fell(pfo_n_reg));
endmodule

// *** dv/ssw_cpu_model.sv ***
// Processor model that toggles or releases the watchdog kick line
`timescale 1ns/10ps
module ssw_cpu_model
  import ssw_pkg::*;
#(
  parameter int unsigned HALF_P = 8
) (
  // Clock
  input wire logic clk_sys,
  // Bench controls
  input wire logic kick_en,
  input wire logic kick_float,
  // Kick line
  output ssw_pkg::ssw_kick_t kick
);
  int cnt = 0;
  logic lvl = 1'b0;
  always @(posedge clk_sys) begin
    cnt <= (cnt + 1) % HALF_P;
    if (kick_en && cnt == 0) begin
      lvl <= ~lvl;
    end
  end
  // Released line has no stable level, so let it wobble
  assign kick.level = kick_float ? cnt[0] : lvl;
  assign kick.floating = kick_float;
endmodule

// *** dv/supply_supervisor_watchdog_test.sv ***
// Self-checking bench for the supply supervisor watchdog
`timescale 1ns/10ps
module supply_supervisor_watchdog_test;
  import ssw_pkg::*;
  localparam int TC = 4;
  localparam int ST = 5;
  localparam int WD = 10;
  localparam int SC = TC * ST;
  localparam int WC = TC * WD;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic supply_low_in = 1'b0;
  logic supply_sense_in = 1'b1;
  logic manual_reset_n = 1'b1;
  logic kick_en = 1'b0;
  logic kick_float = 1'b1;
  ssw_kick_t kick;
  ssw_out_t sup_out;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int req_end = 0;
  int wd_ref = 0;
  logic lvl_q = 1'b0;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  ssw_top #(.STRETCH_TICKS_P(ST), .WDOG_TICKS_P(WD), .TICK_CYC_P(TC)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .supply_low_in(supply_low_in),
    .supply_sense_in(supply_sense_in), .manual_reset_n(manual_reset_n),
    .watchdog_kick_in(kick), .sup_out(sup_out));

  ssw_cpu_model #(.HALF_P(8)) cpu (
    .clk_sys(clk_sys), .kick_en(kick_en), .kick_float(kick_float), .kick(kick));

  // Reference model; margins cover sync delay and tick rounding
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    lvl_q <= kick.level;
    if (!rst_n || supply_low_in || !manual_reset_n) req_end <= cyc;
    if (cyc - req_end <= SC + TC + 4 || kick.floating || kick.level !== lvl_q) wd_ref <= cyc;
  end

  function automatic logic [3:0] model();
    logic rn;
    rn = (cyc - req_end) > SC + TC + 4;
    return {rn, ~rn, ~supply_low_in && (cyc - wd_ref) < WC + 4, supply_sense_in};
  endfunction

  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(7690));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    w(10);
    chk("power-on stretch", sup_out, model());
    w(30);
    chk("power-on release", sup_out, model());
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      supply_sense_in <= 1'($urandom);
      w(5);
      chk("power fail flag", sup_out, model());
    end
    w(2 * WC);
    chk("floating kick", sup_out, model());
    @(posedge clk_sys);
    kick_float <= 1'b0;
    kick_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      w(WC / 2);
      chk("regular kicks", sup_out, model());
    end
    @(posedge clk_sys);
    kick_en <= 1'b0;
    w(WC - 12);
    chk("before timeout", sup_out, model());
    w(20);
    chk("timeout", sup_out, model());
    w(40);
    chk("timeout held", sup_out, model());
    // Exactly one toggle in one model period
    @(posedge clk_sys);
    kick_en <= 1'b1;
    w(7);
    @(posedge clk_sys);
    kick_en <= 1'b0;
    w(8);
    chk("single kick clears", sup_out, model());
    @(posedge clk_sys);
    manual_reset_n <= 1'b0;
    w(WC + 20);
    chk("manual reset held", sup_out, model());
    @(posedge clk_sys);
    manual_reset_n <= 1'b1;
    w(SC - 6);
    chk("manual debounce", sup_out, model());
    w(SC);
    chk("manual release", sup_out, model());
    @(posedge clk_sys);
    supply_low_in <= 1'b1;
    w(6);
    chk("supply low", sup_out, model());
    w(50);
    chk("supply low held", sup_out, model());
    @(posedge clk_sys);
    supply_low_in <= 1'b0;
    w(6);
    chk("supply recovered", sup_out, model());
    w(SC + 10);
    chk("supply release", sup_out, model());
    report_and_stop();
  end
endmodule
